// ==== design/gsbt_pkg.sv ====
/*
 Constants, field layouts and state types for the gated sixteen bit timer.
 Assumes a single 25 MHz clock and an 8-bit register port.
*/
// Overview of operation
// R01: Sixteen bit counter, byte writes load immediately
// R02: Run bit and gate enable decide counting
// R03: Clock select picks oscillator, pin, system, instruction
// R04: Instruction clock gives one count per cycle
// R05: System clock gives four counts per instruction
// R06: External rising edge counts, synchronized or not
// R07: External mode needs falling edge first
// R08: Prescaler divides 1/2/4/8, cleared on writes
// R09: Oscillator enable starts crystal, runs in sleep
// R10: Software waits oscillator start via FC00h preset
// R11: Sync disable bypasses external clock synchronization
// R12: Asynchronous external mode counts during sleep
// R13: Mode switch may drop or add one count
// R14: Byte reads while running return valid values
// R15: Software stops timer before writing count
// R16: Gated counting only while gate active
// R17: Gate polarity selects active low or high
// R18: Gate source pin, timer overflow, comparators
// R19: Rollover FFFFh to 0000h sets overflow flag
// R20: Eight bit timer overflow pulses the gate
// R21: External clock and gates use two-stage synchronizer; the eight bit timer overflow gate source bypasses it
package gsbt_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [2:0] GSBT_OFS_COUNT_LOW = 3'h0;
    localparam logic [2:0] GSBT_OFS_COUNT_HIGH = 3'h1;
    localparam logic [2:0] GSBT_OFS_TIMER_CTL = 3'h2;
    localparam logic [2:0] GSBT_OFS_GATE_CTL = 3'h3;
    localparam logic [2:0] GSBT_OFS_STATUS = 3'h4;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int GSBT_STAT_OVF_BIT = 0;
    localparam int GSBT_STAT_GATE_BIT = 1;
    localparam logic [7:0] GSBT_CTL_RST = 8'h00;
    localparam logic [15:0] GSBT_COUNT_RST = 16'h0000;
    localparam logic [15:0] GSBT_COUNT_MAX = 16'hffff;
    localparam logic [1:0] GSBT_PHASE_LAST = 2'h3;

    // Synchronizer lane positions
    localparam int GSBT_SYN_EXT = 0;
    localparam int GSBT_SYN_XTAL = 1;
    localparam int GSBT_SYN_SENSE = 2;
    localparam int GSBT_SYN_GATE = 3;
    localparam int GSBT_SYN_CMP1 = 4;
    localparam int GSBT_SYN_CMP2 = 5;
    localparam int GSBT_SYN_W = 6;

    typedef enum logic [1:0] {
        GSBT_CLK_INSTR = 2'b00,
        GSBT_CLK_SYS = 2'b01,
        GSBT_CLK_EXT = 2'b10,
        GSBT_CLK_SENSE = 2'b11
    } gsbt_clk_sel_t;

    typedef enum logic [1:0] {
        GSBT_GATE_PIN = 2'b00,
        GSBT_GATE_TMR = 2'b01,
        GSBT_GATE_CMP1 = 2'b10,
        GSBT_GATE_CMP2 = 2'b11
    } gsbt_gate_src_t;

    // timer_control_reg layout
    typedef struct packed {
        gsbt_clk_sel_t clock_select;
        logic [1:0] prescale;
        logic osc_enable;
        logic sync_disable;
        logic spare;
        logic run;
    } gsbt_tctl_t;

    // gate_control_reg layout
    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
        logic [3:0] spare;
        gsbt_gate_src_t gate_source;
    } gsbt_gctl_t;

    // Whole state of the timer
    typedef struct packed {
        logic [15:0] count;
        gsbt_tctl_t tctl;
        gsbt_gctl_t gctl;
        logic overflow_flag;
        logic [2:0] presc_cnt;
        logic [1:0] phase;
        logic armed;
        logic pending;
        logic [GSBT_SYN_W-1:0] sync1;
        logic [GSBT_SYN_W-1:0] sync2;
        logic [GSBT_SYN_W-1:0] prev;
        logic [7:0] rdata;
        logic xtal_out;
        logic gate_val;
    } gsbt_state_t;

endpackage

// ==== design/gsbt_timer.sv ====
/*
 Gated sixteen bit timer: counter, clock selection, prescaler,
 external edge counting and gate control behind an 8-bit register port.
 Assumes pins and comparator outputs are asynchronous, and that the
 eight bit timer overflow pulse and SLEEP come from logic on CLK.
*/
module gsbt_timer
    import gsbt_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic EXT_CLOCK_PIN,
    input wire logic CRYSTAL_IN_PIN,
    output logic CRYSTAL_OUT_PIN,
    input wire logic SENSE_OSC,
    input wire logic GATE_PIN,
    input wire logic EIGHT_BIT_TIMER_OVF,
    input wire logic COMPARATOR_ONE_OUT,
    input wire logic COMPARATOR_TWO_OUT,
    input wire logic SLEEP,
    output logic OVERFLOW_FLAG,
    output logic GATE_VALUE,
    output logic [15:0] COUNT
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    gsbt_state_t s_ff;
    gsbt_state_t nxt_s;

    // Working signals of the next-state logic
    logic ext_lvl;
    logic ext_old;
    logic ext_rise;
    logic ext_fall;
    logic ext_mode;
    logic gate_src;
    logic gate_active;
    logic count_en;
    logic instr_tick;
    logic raw_tick;
    logic inc;
    logic ovf_set;
    logic ovf_clr;
    logic count_wr;
    logic [2:0] div_last;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        raw_tick = 1'b0;
        inc = 1'b0;
        ovf_set = 1'b0;
        ovf_clr = 1'b0;
        count_wr = 1'b0;
        ext_lvl = 1'b0;
        ext_old = 1'b0;
        gate_src = 1'b0;

        // Two-stage synchronizers, then a history stage for edges
        nxt_s.sync1 = {COMPARATOR_TWO_OUT, COMPARATOR_ONE_OUT, GATE_PIN,
                       SENSE_OSC, CRYSTAL_IN_PIN, EXT_CLOCK_PIN}; // [R21]
        nxt_s.sync2 = s_ff.sync1; // [R21]
        nxt_s.prev = s_ff.sync2;

        // Instruction clock phase, system clock divided by four
        nxt_s.phase = s_ff.phase + 2'h1;
        instr_tick = (s_ff.phase == GSBT_PHASE_LAST);

        // Crystal amplifier runs whenever enabled, sleep or not
        nxt_s.xtal_out = s_ff.tctl.osc_enable & ~s_ff.sync2[GSBT_SYN_XTAL]; // [R09]

        // External clock source: pin, crystal or sensing oscillator
        if (s_ff.tctl.clock_select == GSBT_CLK_SENSE) begin
            ext_lvl = s_ff.sync2[GSBT_SYN_SENSE]; // [R03]
            ext_old = s_ff.prev[GSBT_SYN_SENSE];
        end else if (s_ff.tctl.osc_enable) begin
            ext_lvl = s_ff.sync2[GSBT_SYN_XTAL]; // [R09]
            ext_old = s_ff.prev[GSBT_SYN_XTAL];
        end else begin
            ext_lvl = s_ff.sync2[GSBT_SYN_EXT]; // [R03]
            ext_old = s_ff.prev[GSBT_SYN_EXT];
        end
        ext_rise = ext_lvl & ~ext_old;
        ext_fall = ~ext_lvl & ext_old;
        ext_mode = s_ff.tctl.clock_select[1];

        // Gate source selection
        unique case (s_ff.gctl.gate_source)
            GSBT_GATE_PIN: gate_src = s_ff.sync2[GSBT_SYN_GATE]; // [R18]
            GSBT_GATE_TMR: gate_src = EIGHT_BIT_TIMER_OVF; // [R20]
            GSBT_GATE_CMP1: gate_src = s_ff.sync2[GSBT_SYN_CMP1]; // [R18]
            GSBT_GATE_CMP2: gate_src = s_ff.sync2[GSBT_SYN_CMP2]; // [R18]
        endcase

        // Polarity: 0 active low, 1 active high
        gate_active = s_ff.gctl.gate_polarity ? gate_src : ~gate_src; // [R17]
        nxt_s.gate_val = gate_active;

        // Run bit and gate enable combine into a count enable
        count_en = s_ff.tctl.run & (~s_ff.gctl.gate_enable | gate_active); // [R02] [R16]

        // External mode arming: a falling edge must come first
        if (ext_mode && ext_fall) begin
            nxt_s.armed = 1'b1; // [R07]
        end
        if (!s_ff.tctl.run) begin
            nxt_s.armed = 1'b0; // [R07]
        end

        // Raw clock tick from the selected source
        unique case (s_ff.tctl.clock_select)
            GSBT_CLK_INSTR: begin
                raw_tick = instr_tick & ~SLEEP; // [R04]
            end
            GSBT_CLK_SYS: begin
                raw_tick = ~SLEEP; // [R05]
            end
            GSBT_CLK_EXT, GSBT_CLK_SENSE: begin
                if (s_ff.tctl.sync_disable) begin
                    // Asynchronous mode: count on the edge, even in sleep
                    raw_tick = ext_rise & s_ff.armed; // [R06] [R11] [R12]
                    nxt_s.pending = 1'b0; // [R13]
                end else begin
                    // Synchronous mode: edge waits for instruction phase
                    raw_tick = s_ff.pending & instr_tick & ~SLEEP; // [R06]
                    nxt_s.pending = (s_ff.pending & ~raw_tick) | (ext_rise & s_ff.armed);
                end
            end
        endcase

        // Prescaler: terminal count 0, 1, 3 or 7
        div_last = 3'((4'h1 << s_ff.tctl.prescale) - 4'h1); // [R08]
        if (raw_tick && count_en) begin
            // At or past terminal count, so a smaller divider takes effect at once
            if (s_ff.presc_cnt >= div_last) begin
                nxt_s.presc_cnt = 3'h0;
                inc = 1'b1; // [R08]
            end else begin
                nxt_s.presc_cnt = s_ff.presc_cnt + 3'h1;
            end
        end

        // Counter increment and rollover detection
        if (inc) begin
            nxt_s.count = s_ff.count + 16'h0001; // [R01]
            ovf_set = (s_ff.count == GSBT_COUNT_MAX); // [R19]
        end

        // Register writes; a count write overrides the increment in the written byte only
        if (WR) begin
            unique case (ADDR)
                GSBT_OFS_COUNT_LOW: begin
                    nxt_s.count[7:0] = WDATA; // [R01]
                    count_wr = 1'b1;
                end
                GSBT_OFS_COUNT_HIGH: begin
                    nxt_s.count[15:8] = WDATA; // [R01]
                    count_wr = 1'b1;
                end
                GSBT_OFS_TIMER_CTL: begin
                    nxt_s.tctl = gsbt_tctl_t'(WDATA);
                end
                GSBT_OFS_GATE_CTL: begin
                    nxt_s.gctl = gsbt_gctl_t'(WDATA);
                end
                GSBT_OFS_STATUS: begin
                    ovf_clr = WDATA[GSBT_STAT_OVF_BIT];
                end
                default: begin
                end
            endcase
        end

        // A count write clears prescaler, arming and pending edge
        if (count_wr) begin
            nxt_s.presc_cnt = 3'h0; // [R08]
            nxt_s.armed = 1'b0; // [R07]
            nxt_s.pending = 1'b0;
        end

        // Overflow flag: a new rollover wins over a clear
        nxt_s.overflow_flag = ovf_set | (s_ff.overflow_flag & ~ovf_clr); // [R19]

        // Read data for the cycle after the strobe
        if (RD) begin
            unique case (ADDR)
                GSBT_OFS_COUNT_LOW: nxt_s.rdata = s_ff.count[7:0]; // [R14]
                GSBT_OFS_COUNT_HIGH: nxt_s.rdata = s_ff.count[15:8]; // [R14]
                GSBT_OFS_TIMER_CTL: nxt_s.rdata = s_ff.tctl;
                GSBT_OFS_GATE_CTL: nxt_s.rdata = s_ff.gctl;
                GSBT_OFS_STATUS: begin
                    nxt_s.rdata = 8'h00;
                    nxt_s.rdata[GSBT_STAT_OVF_BIT] = s_ff.overflow_flag;
                    nxt_s.rdata[GSBT_STAT_GATE_BIT] = s_ff.gate_val;
                end
                default: nxt_s.rdata = 8'h00;
            endcase
        end else begin
            nxt_s.rdata = 8'h00;
        end
    end

    // ----------------------------------------
    // State register, frozen while CE is low
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_ff <= '0;
            s_ff.count <= GSBT_COUNT_RST;
            s_ff.tctl <= gsbt_tctl_t'(GSBT_CTL_RST);
            s_ff.gctl <= gsbt_gctl_t'(GSBT_CTL_RST);
        end else if (CE) begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // Outputs straight from the state register
    // ----------------------------------------
    assign RDATA = s_ff.rdata;
    assign CRYSTAL_OUT_PIN = s_ff.xtal_out;
    assign OVERFLOW_FLAG = s_ff.overflow_flag;
    assign GATE_VALUE = s_ff.gate_val;
    assign COUNT = s_ff.count;

endmodule

// ==== tb/gsbt_timer_assertions.sv ====
/*
 Port checker of the gated sixteen bit timer, bound into gsbt_timer.
 Assumes one clock and a synchronous active high reset.
*/
module gsbt_timer_assertions
    import gsbt_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic GATE_PIN,
    input wire logic SLEEP,
    input wire logic OVERFLOW_FLAG,
    input wire logic [15:0] COUNT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tctl_q, gctl_q;
    logic [15:0] cnt_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Shadow copies of the control bytes and the last count
    always_ff @(posedge CLK) begin
        cnt_q <= COUNT;
        if (RST) begin
            tctl_q <= 8'h00;
            gctl_q <= 8'h00;
        end else if (CE && WR && ADDR == GSBT_OFS_TIMER_CTL) begin
            tctl_q <= WDATA;
        end else if (CE && WR && ADDR == GSBT_OFS_GATE_CTL) begin
            gctl_q <= WDATA;
        end
    end
    // An instruction clock increment has just happened
    sequence s_inc;
        CE && !WR && tctl_q[7:6] == 2'b00 ##1 COUNT != cnt_q;
    endsequence
    AST_WR_LOW: assert property (CE && WR && ADDR == GSBT_OFS_COUNT_LOW |=> COUNT[7:0] == $past(WDATA))
        else $error("low byte write not loaded");
    AST_RD_HIGH: assert property (CE && RD && ADDR == GSBT_OFS_COUNT_HIGH |=> RDATA == cnt_q[15:8])
        else $error("high byte read wrong");
    AST_RUN_OFF: assert property (!tctl_q[0] && !WR |=> COUNT == cnt_q)
        else $error("count moved while stopped");
    AST_SYS_TICK: assert property (tctl_q == 8'h41 && !gctl_q[7] && CE && !SLEEP && !WR |=> COUNT == cnt_q + 16'h0001)
        else $error("system clock count missed");
    AST_INSTR: assert property (s_inc |=> (COUNT == cnt_q || $past(WR) || tctl_q[7:6] != 2'b00) [*3])
        else $error("instruction clock counted too fast");
    AST_OVF_SET: assert property (CE && !WR && COUNT == 16'hffff ##1 COUNT == 16'h0000 |-> OVERFLOW_FLAG)
        else $error("rollover did not set flag");
    AST_FLAG_CLR: assert property (CE && WR && ADDR == GSBT_OFS_STATUS && WDATA[0] && COUNT != 16'hffff |=> !OVERFLOW_FLAG)
        else $error("flag not cleared");
    AST_FLAG_HOLD: assert property (OVERFLOW_FLAG && !WR |=> OVERFLOW_FLAG)
        else $error("flag lost");
    AST_GATE_HOLD: assert property ((gctl_q[7] && gctl_q[1:0] == 2'b00 && GATE_PIN != gctl_q[6] && !WR) [*4] |=> COUNT == cnt_q)
        else $error("count moved with gate inactive");
endmodule

// ==== tb/gsbt_far_side.sv ====
/*
 Far side of the timer: clock pin, sensing oscillator, crystal, gate pin, comparators.
 Assumes the bench sets the gate levels and calls the burst task.
*/
module gsbt_far_side (
    input wire logic xtal_en,
    input wire logic [2:0] lvl,
    output logic ext_clk,
    output logic sense,
    output logic xtal,
    output logic gate,
    output logic cmp1,
    output logic cmp2
);
    timeunit 1ns;
    timeprecision 1ps;
    // Crystal swings only while enabled, out of phase with CLK
    initial begin
        {ext_clk, sense, xtal} = 3'b000;
        forever #97 xtal = xtal_en & ~xtal;
    end
    // Levels reach the pins a little late
    assign #3 gate = lvl[0];
    assign #3 cmp1 = lvl[1];
    assign #3 cmp2 = lvl[2];
    // Burst of pulses on the pin or the sensing oscillator, still otherwise
    task automatic pulses(input int n, input logic which);
        repeat (n) begin
            #130 {sense, ext_clk} = which ? 2'b10 : 2'b01;
            #130 {sense, ext_clk} = 2'b00;
        end
    endtask
endmodule

// ==== tb/gsbt_timer_bench.sv ====
/*
 Self-checking bench of the gated sixteen bit timer.
 Assumes the checker and the far side model are compiled first.
*/
module gsbt_timer_bench
    import gsbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sleep = 1'b0, ovf = 1'b0, xtal_en = 1'b0, ce = 1'b1;
    logic [2:0] addr = 3'h0, lvl = 3'h7;
    logic [7:0] wdata = 8'h00, rdata, rd_data;
    logic [15:0] count, c0;
    logic [31:0] seed = 32'h808f7682;
    logic [7:0] q[$];
    logic ext_clk, sense, xtal, gate, cmp1, cmp2, flag, act, gv, xo, xo_last;
    int miscompares = 0, num_checks = 0, n, mdl, tog;
    gsbt_far_side U_FAR (.xtal_en(xtal_en), .lvl(lvl), .ext_clk(ext_clk), .sense(sense), .xtal(xtal), .gate(gate),
        .cmp1(cmp1), .cmp2(cmp2));
    gsbt_timer DUT (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .EXT_CLOCK_PIN(ext_clk), .CRYSTAL_IN_PIN(xtal), .CRYSTAL_OUT_PIN(xo), .SENSE_OSC(sense), .GATE_PIN(gate),
        .EIGHT_BIT_TIMER_OVF(ovf), .COMPARATOR_ONE_OUT(cmp1), .COMPARATOR_TWO_OUT(cmp2), .SLEEP(sleep),
        .OVERFLOW_FLAG(flag), .GATE_VALUE(gv), .COUNT(count));
    // Clock and watchdog
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) {wr_s, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk) {rd_s, addr} <= {1'b1, a};
        @(posedge clk) rd_s <= 1'b0;
        #1 rd_data = rdata;
    endtask
    // Stop the timer, then load both bytes
    task automatic clr(input logic [7:0] hi, input logic [7:0] lo);
        wr(GSBT_OFS_TIMER_CTL, 8'h00);
        wr(GSBT_OFS_COUNT_LOW, lo);
        wr(GSBT_OFS_COUNT_HIGH, hi);
        mdl = {hi, lo};
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            chk({8'h00, rd_data}, 16'h0000);
        end
        repeat (4) begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
            q.push_back(seed[15:8]);
            clr(seed[15:8], seed[7:0]);
            chk(count, mdl[15:0]);
            rd(GSBT_OFS_COUNT_LOW);
            chk({8'h00, rd_data}, {8'h00, q.pop_front()});
            rd(GSBT_OFS_COUNT_HIGH);
            chk({8'h00, rd_data}, {8'h00, q.pop_front()});
        end
        wr(GSBT_OFS_GATE_CTL, 8'h80);
        wr(GSBT_OFS_TIMER_CTL, 8'h40);
        c0 = count;
        cyc(20);
        chk(count, c0);
        wr(GSBT_OFS_GATE_CTL, 8'h00);
        // Eight increments per window for every internal source and divider
        for (int k = 0; k < 8; k++) begin
            clr(8'h00, 8'h00);
            wr(GSBT_OFS_TIMER_CTL, {1'b0, k[2], k[1:0], 4'h1});
            cyc(6);
            c0 = count;
            cyc((k[2] ? 8 : 32) << k[1:0]);
            chk(count - c0, 16'h0008);
        end
        // Clock enable low freezes the running count
        @(posedge clk) ce <= 1'b0;
        #1 c0 = count;
        cyc(12);
        chk(count, c0);
        @(posedge clk) ce <= 1'b1;
        // Four pulses count three: the first rise lacks a falling edge
        for (int k = 0; k < 4; k++) begin
            clr(8'h00, 8'h00);
            @(posedge clk) sleep <= k[1];
            wr(GSBT_OFS_TIMER_CTL, {1'b1, k[0], 2'b00, 1'b0, k[1], 1'b0, 1'b1});
            U_FAR.pulses(4, k[0]);
            cyc(10);
            chk(count, 16'h0003);
            rd(GSBT_OFS_COUNT_LOW);
            chk({8'h00, rd_data}, 16'h0003);
        end
        @(posedge clk) sleep <= 1'b0;
        // Crystal start-up wait: preset, clear flag, wait for rollover
        clr(8'hfc, 8'h00);
        wr(GSBT_OFS_STATUS, 8'h01);
        xtal_en = 1'b1;
        wr(GSBT_OFS_TIMER_CTL, 8'h8d);
        n = 0;
        tog = 0;
        xo_last = xo;
        // Amplifier output follows every crystal edge while enabled
        while (flag !== 1'b1 && n < 8000) begin
            cyc(1);
            n++;
            tog += (xo !== xo_last);
            xo_last = xo;
        end
        chk({15'h0000, n > 4900 && n < 5040}, 16'h0001);
        chk({15'h0000, tog > 2030 && tog < 2070}, 16'h0001);
        clr(8'h00, 8'h00);
        xtal_en = 1'b0;
        chk({15'h0000, xo}, 16'h0000);
        rd(GSBT_OFS_STATUS);
        chk({15'h0000, rd_data[0]}, 16'h0001);
        wr(GSBT_OFS_STATUS, 8'h01);
        rd(GSBT_OFS_STATUS);
        chk({15'h0000, rd_data[0]}, 16'h0000);
        // Every gate source and polarity, both levels except timer overflow (held low); other sources opposite
        wr(GSBT_OFS_TIMER_CTL, 8'h41);
        for (int k = 0; k < 16; k++) begin
            lvl = {3{~k[0]}} ^ {k[3:2] == 2'd3, k[3:2] == 2'd2, k[3:2] == 2'd0};
            act = ((k[3:2] == 2'd1) ? 1'b0 : k[0]) == k[1];
            wr(GSBT_OFS_GATE_CTL, {1'b1, k[1], 4'h0, k[3:2]});
            cyc(6);
            c0 = count;
            cyc(16);
            chk(count - c0, act ? 16'h0010 : 16'h0000);
            rd(GSBT_OFS_STATUS);
            chk({15'h0000, rd_data[1]}, {15'h0000, act});
            chk({15'h0000, gv}, {15'h0000, act});
        end
        // One overflow pulse of the eight bit timer lets one count through
        wr(GSBT_OFS_GATE_CTL, 8'hc1);
        cyc(4);
        c0 = count;
        @(posedge clk) ovf <= 1'b1;
        @(posedge clk) ovf <= 1'b0;
        cyc(6);
        chk(count - c0, 16'h0001);
        print_verdict;
    end
endmodule
bind gsbt_timer gsbt_timer_assertions U_CHK (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .GATE_PIN(GATE_PIN), .SLEEP(SLEEP), .OVERFLOW_FLAG(OVERFLOW_FLAG), .COUNT(COUNT));
